// ---- logic/sef_socket_event_force.v ----
// Socket event force logic with the Event and Present State bits it drives.
// Reset returns every Event field, the stored Present fields and the inhibit to zero; the detect bits read one.
// Assumes register strobes on ref_clk, socket pins asynchronous to it, and
// supply_on from the power sequencer on the same clock.

`timescale 1ns/100ps
`include "sef_map.vh"

module sef_socket_event_force
(
    // Clock and reset
    input  wire        ref_clk,
    input  wire        resetn,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Socket pins, asynchronous
    input  wire        detect_pin_one_n,
    input  wire        detect_pin_two_n,
    input  wire [1:0]  voltage_sense_pins,
    input  wire        card_status_change,
    input  wire        video_port_strap,
    // Power sequencer, same clock
    input  wire        supply_on,
    // Status outputs
    output reg         vcc_power_inhibit,
    output reg         card_present
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    reg  [5:0] pin_meta_r;
    reg  [5:0] pin_sync_r;
    wire [5:0] pin_raw;

    assign pin_raw = {video_port_strap, card_status_change, voltage_sense_pins,
                      detect_pin_two_n, detect_pin_one_n};

    // Two stages; only the second is read by logic
    // Reset loads each pin's idle level: detect and sense high, others low
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pin_meta_r <= `SEF_RST_PINS;
            pin_sync_r <= `SEF_RST_PINS;
        end
        else
        begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    wire       det_one_s = pin_sync_r[0];
    wire       det_two_s = pin_sync_r[1];
    wire [1:0] sense_s   = pin_sync_r[3:2];
    wire       sts_chg_s = pin_sync_r[4];
    wire       strap_s   = pin_sync_r[5];

    // Both detect pins low means a card sits in the socket
    wire card_in = ~det_one_s & ~det_two_s;

    // ---------------------------------------------------------------
    // Previous pin levels for event edges
    // ---------------------------------------------------------------
    reg det_one_d_r;
    reg det_two_d_r;
    reg sts_chg_d_r;
    reg supply_d_r;

    // Delayed copies of synchronised levels, not of the first stage
    // Status change idles low behind its pull-down, so its copy resets low
    // Supply is off after reset, so a low copy raises no false power edge
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            det_one_d_r <= 1'b1;
            det_two_d_r <= 1'b1;
            sts_chg_d_r <= 1'b0;
            supply_d_r  <= 1'b0;
        end
        else
        begin
            det_one_d_r <= det_one_s;
            det_two_d_r <= det_two_s;
            sts_chg_d_r <= sts_chg_s;
            supply_d_r  <= supply_on;
        end
    end

    // ---------------------------------------------------------------
    // Start-up gate
    // ---------------------------------------------------------------
    reg [1:0] warm_r;

    // Pins need the sync depth plus one edge before their levels mean anything;
    // a real pin edge in this window raises no event, the price of no false one
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            warm_r <= 2'h0;
        else if (warm_r != `SEF_WARM_DONE)
            warm_r <= warm_r + 2'h1;
    end
    wire ready = (warm_r == `SEF_WARM_DONE);

    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    // Unmapped addresses decode nothing, so their writes are dropped
    wire wr_force   = reg_wr & (reg_addr == `SEF_OFS_FORCE);
    wire wr_event   = reg_wr & (reg_addr == `SEF_OFS_EVENT);
    wire wr_present = reg_wr & (reg_addr == `SEF_OFS_PRESENT);

    // Force strobes per bit; reserved and extra voltage bits never decoded
    wire f_sts   = wr_force & reg_wdata[`SEF_BIT_STS_CHG];   // Zero is no-op
    wire f_one   = wr_force & reg_wdata[`SEF_BIT_DET_ONE];
    wire f_two   = wr_force & reg_wdata[`SEF_BIT_DET_TWO];
    wire f_pwr   = wr_force & reg_wdata[`SEF_BIT_POWER];
    wire f_rtst  = wr_force & reg_wdata[`SEF_BIT_RETEST];
    wire f_video = wr_force & reg_wdata[`SEF_BIT_VIDEO];
    wire f_type  = wr_force & ~card_in;

    // ---------------------------------------------------------------
    // Event register: sticky, cleared by writing one
    // ---------------------------------------------------------------
    reg  [3:0] event_r;
    wire [3:0] event_set;
    wire [3:0] event_clr;

    // Live pin edges or forced bits raise events
    // Power edges ungated: supply_on shares this clock and needs no warm-up
    assign event_set[`SEF_BIT_STS_CHG] = f_sts | (ready & sts_chg_s & ~sts_chg_d_r);
    assign event_set[`SEF_BIT_DET_ONE] = f_one | (ready & (det_one_s ^ det_one_d_r));
    assign event_set[`SEF_BIT_DET_TWO] = f_two | (ready & (det_two_s ^ det_two_d_r));
    assign event_set[`SEF_BIT_POWER]   = f_pwr | (supply_on ^ supply_d_r);
    assign event_clr = wr_event ? reg_wdata[3:0] : 4'h0;

    // Set wins over a same-cycle clear so no event is lost
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            event_r <= `SEF_RST_EVENT;
        else
            event_r <= (event_r & ~event_clr) | event_set;
    end

    // ---------------------------------------------------------------
    // Present state: forced and sampled fields
    // ---------------------------------------------------------------
    reg card16_r;
    reg card32_r;
    reg unknown_r;
    reg data_loss_r;
    reg bad_supply_r;
    reg high_volt_r;
    reg low_volt_r;
    reg video_r;
    reg retest_pend_r;

    // Card type fields follow force data only with the socket empty
    // Presence is judged from the synced pins at the write edge
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            card16_r  <= `SEF_RST_FLAGS;
            card32_r  <= `SEF_RST_FLAGS;
            unknown_r <= `SEF_RST_FLAGS;
        end
        else if (f_type)
        begin
            card16_r  <= reg_wdata[`SEF_BIT_CARD16];
            card32_r  <= reg_wdata[`SEF_BIT_CARD32];
            unknown_r <= reg_wdata[`SEF_BIT_UNKNOWN];
        end
    end

    // Supply status flags written straight from force data
    // Plain copy; no hardware event sets this flag here
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            bad_supply_r <= `SEF_RST_FLAGS;
        else if (wr_force)
            bad_supply_r <= reg_wdata[`SEF_BIT_BAD_SUPPLY];
    end

    // Data loss: a force write wins over the write-one clear
    // One address per cycle, so the two never meet in practice
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            data_loss_r <= `SEF_RST_FLAGS;
        else if (wr_force)
            data_loss_r <= reg_wdata[`SEF_BIT_DATA_LOSS];
        else if (wr_present & reg_wdata[`SEF_BIT_DATA_LOSS])
            data_loss_r <= 1'b0;
    end

    // Video port capability: strap keeps it set, force may set it
    // Sticky: once reported, only reset takes the capability back
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            video_r <= `SEF_RST_FLAGS;
        else if (f_video | (ready & strap_s))
            video_r <= 1'b1;
    end

    // ---------------------------------------------------------------
    // Voltage capability and retest
    // ---------------------------------------------------------------
    // Retest after reset too, so the first fields come from the pins
    // A retest asked for during start-up waits for the gate, never lost
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            retest_pend_r <= 1'b1;
        else if (f_rtst)
            retest_pend_r <= 1'b1;
        else if (ready)
            retest_pend_r <= 1'b0;
    end

    // Sense decode: each low sense pin grants one supply level
    wire sample = retest_pend_r & ready;

    // A force in the same cycle as a sample wins: software spoke last
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            high_volt_r <= `SEF_RST_FLAGS;
            low_volt_r  <= `SEF_RST_FLAGS;
        end
        else if (wr_force)
        begin
            high_volt_r <= reg_wdata[`SEF_BIT_HIGH_VOLT];
            low_volt_r  <= reg_wdata[`SEF_BIT_LOW_VOLT];
        end
        else if (sample)
        begin
            high_volt_r <= card_in & ~sense_s[1];
            low_volt_r  <= card_in & ~sense_s[0];
        end
    end

    // ---------------------------------------------------------------
    // Power-up inhibit
    // ---------------------------------------------------------------
    reg  inhibit_r;
    wire f_high      = wr_force & reg_wdata[`SEF_BIT_HIGH_VOLT];
    wire f_low       = wr_force & reg_wdata[`SEF_BIT_LOW_VOLT];
    wire volt_forced = f_high | f_low;

    // Inhibit: set by a forced voltage, lifted only by retest or reset;
    // writing both fields zero leaves an earlier inhibit standing
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            inhibit_r <= 1'b0;
        else if (volt_forced)
            inhibit_r <= 1'b1;
        else if (sample)
            inhibit_r <= 1'b0;
    end

    // ---------------------------------------------------------------
    // Present word assembly
    // ---------------------------------------------------------------
    reg [31:0] present_word;

    // Live bits follow the pins and power, never the force register
    // Bits 31-28, 26-12 and 6 always read zero
    always @*
    begin
        present_word                     = 32'h0000_0000;
        present_word[`SEF_BIT_STS_CHG]   = sts_chg_s;
        present_word[`SEF_BIT_DET_ONE]   = det_one_s;
        present_word[`SEF_BIT_DET_TWO]   = det_two_s;
        present_word[`SEF_BIT_POWER]     = supply_on;
        present_word[`SEF_BIT_CARD16]    = card16_r;
        present_word[`SEF_BIT_CARD32]    = card32_r;
        present_word[`SEF_BIT_UNKNOWN]   = unknown_r;
        present_word[`SEF_BIT_DATA_LOSS] = data_loss_r;
        present_word[`SEF_BIT_BAD_SUPPLY]= bad_supply_r;
        present_word[`SEF_BIT_HIGH_VOLT] = high_volt_r;
        present_word[`SEF_BIT_LOW_VOLT]  = low_volt_r;
        present_word[`SEF_BIT_VIDEO]     = video_r;
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    reg [31:0] rd_mux;

    // Force register has no storage and reads zero
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            `SEF_OFS_EVENT:   rd_mux = {28'h0000000, event_r};
            `SEF_OFS_PRESENT: rd_mux = present_word;
            `SEF_OFS_FORCE:   rd_mux = 32'h0000_0000;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Data stand one cycle after the strobe, zero otherwise
    // Zero between reads keeps stale status off the bus
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= `SEF_RST_RDATA;
        else if (reg_rd)
            reg_rdata <= rd_mux;
        else
            reg_rdata <= `SEF_RST_RDATA;
    end

    // ---------------------------------------------------------------
    // Registered status outputs
    // ---------------------------------------------------------------
    // Extra stage keeps outputs straight from flip-flops; costs one cycle
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            vcc_power_inhibit <= 1'b0;
            card_present      <= 1'b0;
        end
        else
        begin
            vcc_power_inhibit <= inhibit_r;
            card_present      <= card_in;
        end
    end

endmodule

// ---- logic/sef_map.vh ----
// Constants for the socket event force block: register offsets, bit positions,
// reset values. Assumes a byte-addressed register port with 32-bit words.

`ifndef SEF_MAP_VH
`define SEF_MAP_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SEF_OFS_EVENT        8'h00
`define SEF_OFS_PRESENT      8'h08
`define SEF_OFS_FORCE        8'h0c

// ---------------------------------------------------------------
// Bit positions, shared by force, event and present words
// ---------------------------------------------------------------
`define SEF_BIT_STS_CHG      0
`define SEF_BIT_DET_ONE      1
`define SEF_BIT_DET_TWO      2
`define SEF_BIT_POWER        3
`define SEF_BIT_CARD16       4
`define SEF_BIT_CARD32       5
`define SEF_BIT_UNKNOWN      7
`define SEF_BIT_DATA_LOSS    8
`define SEF_BIT_BAD_SUPPLY   9
`define SEF_BIT_HIGH_VOLT    10
`define SEF_BIT_LOW_VOLT     11
`define SEF_BIT_EXTRA_X      12
`define SEF_BIT_EXTRA_Y      13
`define SEF_BIT_RETEST       14
`define SEF_BIT_VIDEO        27

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SEF_RST_EVENT        4'h0
`define SEF_RST_FLAGS        1'b0
`define SEF_RST_RDATA        32'h0000_0000
`define SEF_RST_PINS         6'h0f

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define SEF_WARM_DONE        2'h3

`endif

// ---- test/sef_socket_model.sv ----
// Socket side model: card detect, voltage sense and status change pins.
// Assumes pull-ups on detect and sense pins and a pull-down on status change.
`timescale 1ns/100ps

module sef_socket_model
#(
    parameter SKEW_NS = 3
)
(
    // Bench controls
    input  wire       card_in,
    input  wire [1:0] grant,
    input  wire       sts_level,
    // Socket pins
    output reg        detect_pin_one_n = 1'b1,
    output reg        detect_pin_two_n = 1'b1,
    output reg  [1:0] voltage_sense_pins = 2'h3,
    output wire       card_status_change
);
    // Contacts make one after the other, so the sync sees a ragged insert
    always @(card_in or grant)
    begin
        detect_pin_one_n <= #1 !card_in;
        detect_pin_two_n <= #SKEW_NS !card_in;
        voltage_sense_pins <= #SKEW_NS (card_in ? ~grant : 2'h3);
    end
    // Empty socket leaves the pull-down in charge
    assign card_status_change = card_in & sts_level;
endmodule

// ---- test/sef_checker.sv ----
// Port checker for the socket event force block.
// Assumes the map header is on the include path; bound at the file foot.
`timescale 1ns/100ps
`include "sef_map.vh"

module sef_checker
(
    // Clock and reset
    input wire        ref_clk,
    input wire        resetn,
    // Register port
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // Socket and power
    input wire        detect_pin_one_n,
    input wire        detect_pin_two_n,
    input wire [1:0]  voltage_sense_pins,
    input wire        card_status_change,
    input wire        video_port_strap,
    input wire        supply_on,
    input wire        vcc_power_inhibit,
    input wire        card_present
);
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    reg  [1:0] warm_r;
    wire       frc_wr = reg_wr && reg_addr == `SEF_OFS_FORCE;
    wire       retest = frc_wr && reg_wdata[`SEF_BIT_RETEST];
    wire       prs_rd = reg_rd && reg_addr == `SEF_OFS_PRESENT;

    // Retest is only honoured once the pin samplers have warmed up
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            warm_r <= 2'h0;
        else if (warm_r != 2'h3)
            warm_r <= warm_r + 2'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    force_read_a: assert property (
        reg_rd && reg_addr == `SEF_OFS_FORCE |=> reg_rdata == 32'h0)
        else $error("force register read returned data");
    inhibit_set_a: assert property (
        frc_wr && (reg_wdata[10] || reg_wdata[11]) |-> ##2 vcc_power_inhibit)
        else $error("forced voltage did not block power up");
    inhibit_clear_a: assert property (
        retest && !reg_wdata[10] && !reg_wdata[11] && warm_r == 2'h3
        ##1 !(frc_wr && (reg_wdata[10] || reg_wdata[11]))
        |-> ##2 !vcc_power_inhibit)
        else $error("retest did not lift power inhibit");
    inhibit_hold_a: assert property (
        $fell(vcc_power_inhibit) |-> $past(retest, 3))
        else $error("power inhibit dropped without retest");
    detect_follow_a: assert property (
        $stable({detect_pin_one_n, detect_pin_two_n}) [*8]
        |-> card_present == (!detect_pin_one_n && !detect_pin_two_n))
        else $error("card present does not follow detect pins");
    event_force_a: assert property (
        frc_wr ##1 reg_rd && reg_addr == `SEF_OFS_EVENT
        |=> (reg_rdata[3:0] & $past(reg_wdata[3:0], 2)) == $past(reg_wdata[3:0], 2))
        else $error("forced event bit not set");
    video_force_a: assert property (
        frc_wr && reg_wdata[`SEF_BIT_VIDEO] ##1 prs_rd |=> reg_rdata[27])
        else $error("video capable bit not set by force");
    reserved_zero_a: assert property (
        prs_rd |=> (reg_rdata & 32'hf7ff_f040) == 32'h0)
        else $error("reserved present bits read nonzero");
    event_upper_a: assert property (
        reg_rd && reg_addr == `SEF_OFS_EVENT |=> reg_rdata[31:4] == 28'h0)
        else $error("upper event bits read nonzero");

    // Main scenarios reached
    cover property (retest ##2 !vcc_power_inhibit);
    cover property (card_present);
    cover property (frc_wr && reg_wdata[0]);
endmodule

bind sef_socket_event_force sef_checker u_chk
(
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .detect_pin_one_n(detect_pin_one_n),
    .detect_pin_two_n(detect_pin_two_n), .voltage_sense_pins(voltage_sense_pins),
    .card_status_change(card_status_change), .video_port_strap(video_port_strap),
    .supply_on(supply_on), .vcc_power_inhibit(vcc_power_inhibit),
    .card_present(card_present)
);

// ---- test/tb.sv ----
// Self-checking bench for the socket event force block.
// Assumes the checker binds itself and the socket model drives the pins.
`timescale 1ns/100ps
`include "sef_map.vh"

module tb;
    reg         ref_clk = 1'b0;
    reg         resetn = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         video_port_strap = 1'b0;
    reg         supply_on = 1'b0;
    reg         card_in = 1'b0;
    reg  [1:0]  grant = 2'h0;
    reg         sts_level = 1'b0;
    wire [31:0] reg_rdata;
    wire        det_one_n;
    wire        det_two_n;
    wire [1:0]  sense;
    wire        sts_pin;
    wire        inhibit;
    wire        card_present;
    integer     err_count = 0;
    integer     checks_done = 0;
    integer     i;

    // 250 MHz
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    sef_socket_model u_sock (.card_in(card_in), .grant(grant), .sts_level(sts_level),
        .detect_pin_one_n(det_one_n), .detect_pin_two_n(det_two_n),
        .voltage_sense_pins(sense), .card_status_change(sts_pin));

    sef_socket_event_force u_dut (.ref_clk(ref_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .detect_pin_one_n(det_one_n), .detect_pin_two_n(det_two_n),
        .voltage_sense_pins(sense), .card_status_change(sts_pin),
        .video_port_strap(video_port_strap), .supply_on(supply_on),
        .vcc_power_inhibit(inhibit), .card_present(card_present));

    // ----------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // Strobe stays up until the next task lowers it, allowing back to back use
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    end
    endtask

    // Data stand only in the cycle after the strobe
    task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    end
    endtask

    task idle(input integer n);
    begin
        repeat (n)
        begin
            @(posedge ref_clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
    end
    endtask

    task tdone(input integer n);
    begin
        $display("test %0d finished, mismatches %0d", n, err_count);
    end
    endtask

    task final_report;
    begin
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // Hang guard
    initial
    begin
        #200000;
        err_count = err_count + 1;
        final_report;
    end

    // ----------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        idle(6);
        rd(`SEF_OFS_EVENT, 32'hffff_ffff, 32'h0);
        rd(`SEF_OFS_PRESENT, 32'hffff_ffff, 32'h6);
        rd(`SEF_OFS_FORCE, 32'hffff_ffff, 32'h0);
        rd(8'h04, 32'hffff_ffff, 32'h0);
        chk({31'h0, card_present}, 32'h0);
        tdone(1);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`SEF_OFS_FORCE, 32'h0);
            rd(`SEF_OFS_EVENT, 32'hf, 32'h0);
            wr(`SEF_OFS_FORCE, 32'h1 << i);
            rd(`SEF_OFS_EVENT, 32'hf, 32'h1 << i);
            rd(`SEF_OFS_PRESENT, 32'hf, 32'h6);
            wr(`SEF_OFS_EVENT, 32'hf);
        end
        tdone(2);
        wr(`SEF_OFS_FORCE, 32'hf7ff_b040);
        rd(`SEF_OFS_PRESENT, 32'hffff_ffff, 32'h6);
        rd(`SEF_OFS_EVENT, 32'hffff_ffff, 32'h0);
        chk({31'h0, inhibit}, 32'h0);
        tdone(3);
        wr(`SEF_OFS_FORCE, 32'h3b0);
        rd(`SEF_OFS_PRESENT, 32'h3b0, 32'h3b0);
        wr(`SEF_OFS_FORCE, 32'h0);
        rd(`SEF_OFS_PRESENT, 32'h3b0, 32'h0);
        wr(`SEF_OFS_FORCE, 32'h100);
        wr(`SEF_OFS_PRESENT, 32'h100);
        rd(`SEF_OFS_PRESENT, 32'h100, 32'h0);
        tdone(4);
        wr(`SEF_OFS_FORCE, 32'hc00);
        rd(`SEF_OFS_PRESENT, 32'hc00, 32'hc00);
        @(posedge ref_clk);
        card_in <= 1'b1;
        grant <= 2'h2;
        idle(10);
        #1;
        chk({31'h0, inhibit}, 32'h1);
        chk({31'h0, card_present}, 32'h1);
        rd(`SEF_OFS_PRESENT, 32'h6, 32'h0);
        wr(`SEF_OFS_FORCE, 32'h4000);
        idle(4);
        #1;
        chk({31'h0, inhibit}, 32'h0);
        rd(`SEF_OFS_PRESENT, 32'hc00, 32'h400);
        wr(`SEF_OFS_FORCE, 32'hb0);
        rd(`SEF_OFS_PRESENT, 32'hb0, 32'h0);
        @(posedge ref_clk);
        grant <= 2'h1;
        idle(4);
        wr(`SEF_OFS_FORCE, 32'h4000);
        idle(2);
        rd(`SEF_OFS_PRESENT, 32'hc00, 32'h800);
        tdone(5);
        @(posedge ref_clk);
        supply_on <= 1'b1;
        sts_level <= 1'b1;
        idle(5);
        rd(`SEF_OFS_PRESENT, 32'h9, 32'h9);
        rd(`SEF_OFS_EVENT, 32'hf, 32'hf);
        wr(`SEF_OFS_FORCE, 32'h0800_0000);
        rd(`SEF_OFS_PRESENT, 32'h0800_0000, 32'h0800_0000);
        tdone(6);
        wr(`SEF_OFS_FORCE, 32'h800);
        idle(2);
        resetn <= 1'b0;
        video_port_strap <= 1'b1;
        idle(20);
        resetn <= 1'b1;
        idle(6);
        #1;
        chk({31'h0, inhibit}, 32'h0);
        rd(`SEF_OFS_PRESENT, 32'h0800_0000, 32'h0800_0000);
        tdone(7);
        final_report;
    end
endmodule
